// ---- logic/exec_unit_regs.vh ----
// Constants shared by the branch and load/store execution unit
`ifndef EXEC_UNIT_REGS_VH
`define EXEC_UNIT_REGS_VH

// ----------------------------------------------------------------
// Instruction word layout
// ----------------------------------------------------------------
`define INSTR_W 24
`define F_OP 23:20
`define F_COND 19:16
`define F_SEL 15:13
`define F_K 6:0
`define F_RD 19:15
`define F_RR 14:10
`define F_PTR 14:13
`define F_MODE 12:11
`define F_Q 5:0
`define F_IMM 7:0

// ----------------------------------------------------------------
// Operation classes
// ----------------------------------------------------------------
`define OP_BRANCH 4'h1
`define OP_COPY 4'h2
`define OP_PAIR_COPY 4'h3
`define OP_IMM 4'h4
`define OP_PTR_READ 4'h5
`define OP_PTR_WRITE 4'h6
`define OP_OFS_READ 4'h7
`define OP_DIR_READ 4'h8

// ----------------------------------------------------------------
// Branch condition codes
// ----------------------------------------------------------------
`define COND_SEL_SET 4'h0
`define COND_SEL_CLEAR 4'h1
`define COND_EQUAL 4'h2
`define COND_NOT_EQUAL 4'h3
`define COND_CARRY_SET 4'h4
`define COND_CARRY_CLEAR 4'h5
`define COND_MINUS 4'h6
`define COND_PLUS 4'h7
`define COND_SIGNED_GE 4'h8
`define COND_SIGNED_LT 4'h9
`define COND_HALF_SET 4'hA
`define COND_HALF_CLEAR 4'hB
`define COND_INT_ON 4'hC
`define COND_INT_OFF 4'hD

// ----------------------------------------------------------------
// Status flag bit positions
// ----------------------------------------------------------------
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`define FLAG_T 6
`define FLAG_I 7

// ----------------------------------------------------------------
// Pointer pairs and addressing modes
// ----------------------------------------------------------------
`define PTR_X 2'h0
`define PTR_Y 2'h1
`define PTR_Z 2'h2
`define PTR_X_BASE 5'h1A
`define PTR_Y_BASE 5'h1C
`define PTR_Z_BASE 5'h1E
`define MODE_PLAIN 2'h0
`define MODE_POST_INC 2'h1
`define MODE_PRE_DEC 2'h2
`define PTR_ONE 16'h0001

// ----------------------------------------------------------------
// Software port map, states, reset values
// ----------------------------------------------------------------
`define BUS_AREA_BIT 5
`define BUS_FLAGS 6'h20
`define BUS_PC_LO 6'h21
`define BUS_PC_HI 6'h22
`define ST_IDLE 2'h0
`define ST_FLUSH 2'h1
`define ST_MEM 2'h2
`define FLAGS_RESET 8'h00
`define PC_RESET 16'h0000
`define REG_RESET 8'h00
`define PC_STEP 16'h0001

`endif

// ---- logic/branch_condition.v ----
// Branch condition evaluation against the status flags
`timescale 1ns/1ps
`include "exec_unit_regs.vh"

module branch_condition (
    input wire [3:0] cond, // Condition code
    input wire [2:0] sel, // Flag index for the generic forms
    input wire [7:0] flags, // Current status flags
    output reg taken // Condition holds
);

    wire signed_lt;

    assign signed_lt = flags[`FLAG_N] ^ flags[`FLAG_V];

    always @* begin
        case (cond)
            `COND_SEL_SET: taken = flags[sel];
            `COND_SEL_CLEAR: taken = ~flags[sel];
            `COND_EQUAL: taken = flags[`FLAG_Z];
            `COND_NOT_EQUAL: taken = ~flags[`FLAG_Z];
            `COND_CARRY_SET: taken = flags[`FLAG_C];
            `COND_CARRY_CLEAR: taken = ~flags[`FLAG_C];
            `COND_MINUS: taken = flags[`FLAG_N];
            `COND_PLUS: taken = ~flags[`FLAG_N];
            `COND_SIGNED_GE: taken = ~signed_lt;
            `COND_SIGNED_LT: taken = signed_lt;
            `COND_HALF_SET: taken = flags[`FLAG_H];
            `COND_HALF_CLEAR: taken = ~flags[`FLAG_H];
            `COND_INT_ON: taken = flags[`FLAG_I];
            `COND_INT_OFF: taken = ~flags[`FLAG_I];
            default: taken = 1'b0;
        endcase
    end

endmodule // branch_condition

// ---- logic/pointer_address_unit.v ----
// Effective address and pointer update for pointer-pair accesses
`timescale 1ns/1ps
`include "exec_unit_regs.vh"

module pointer_address_unit #(
    parameter ADDR_W = 16, // Data-space address width
    parameter Q_W = 6 // Displacement width
) (
    input wire [ADDR_W-1:0] ptr_value, // Current pointer pair value
    input wire [1:0] mode, // Plain, post-increment or pre-decrement
    input wire [Q_W-1:0] q, // Unsigned displacement
    input wire use_disp, // Displacement form
    output reg [ADDR_W-1:0] access_addr, // Address of the access
    output reg [ADDR_W-1:0] ptr_next, // Pointer value after the access
    output reg ptr_write, // Pointer pair changes
    output wire mode_legal // Mode code is defined
);

    localparam Q_PAD = ADDR_W - Q_W;

    assign mode_legal = use_disp | (mode != 2'h3);

    always @* begin
        access_addr = ptr_value;
        ptr_next = ptr_value;
        ptr_write = 1'b0;
        if (use_disp) begin
            access_addr = ptr_value + {{Q_PAD{1'b0}}, q};
        end else begin
            case (mode)
                `MODE_POST_INC: begin
                    ptr_next = ptr_value + `PTR_ONE;
                    ptr_write = 1'b1;
                end
                `MODE_PRE_DEC: begin
                    ptr_next = ptr_value - `PTR_ONE;
                    access_addr = ptr_value - `PTR_ONE;
                    ptr_write = 1'b1;
                end
                default: ptr_write = 1'b0;
            endcase
        end
    end

endmodule // pointer_address_unit

// ---- logic/branch_and_load_store_exec.v ----
// Execution unit for conditional branches and data-transfer instructions
//
// Operation
// - Generic branches test flag s; set or clear form adds k plus one.
// - Equal branch taken on zero set, not-equal on zero clear.
// - Carry set or lower taken on carry one; clear or higher on zero.
// - Minus branch taken on negative one, plus branch on negative zero.
// - Signed greater-or-equal taken when N xor V is zero; less when one.
// - Half-carry set and clear branches test the half-carry flag.
// - Interrupt on and off branches test global enable; flags untouched.
// - Loads through any pointer pair, plain or post-increment, in two cycles.
// - Pre-decrement load lowers pointer first, then reads, two cycles.
// - Displacement load via second or third pair, pointer kept, two cycles.
// - Direct load from an immediate data-space address in two cycles.
// - Store via any pointer pair, plain or post-increment, two cycles.
// - Pre-decrement store lowers pointer first, then writes, two cycles.
`timescale 1ns/1ps
`include "exec_unit_regs.vh"

module branch_and_load_store_exec #(
    parameter PC_W = 16, // Program counter width
    parameter ADDR_W = 16 // Data-space address width
) (
    input wire sys_clk, // Core clock
    input wire reset, // Synchronous reset, active high
    input wire ce, // Clock enable, freezes all state when low
    input wire instr_valid, // Instruction word offered
    input wire [`INSTR_W-1:0] instr_word, // Instruction word
    input wire [ADDR_W-1:0] instr_addr, // Address word for direct loads
    output wire instr_ready, // Unit accepts an instruction this cycle
    output reg flush_q, // Fetched next word is discarded
    output reg [PC_W-1:0] program_counter_q, // Program counter
    output reg [7:0] status_flags_register_q, // Status flags
    output reg [ADDR_W-1:0] mem_addr_q, // Data-space address
    output reg [7:0] mem_wdata_q, // Data-space write data
    output reg mem_re_q, // Data-space read strobe
    output reg mem_we_q, // Data-space write strobe
    input wire [7:0] mem_rdata, // Read data, valid while mem_re_q is high
    input wire [5:0] bus_addr, // Software port address
    input wire [7:0] bus_wdata, // Software port write data
    input wire bus_we, // Software port write strobe
    input wire bus_re, // Software port read strobe
    output reg [7:0] bus_rdata_q // Software port read data
);

    localparam K_W = 7;
    localparam K_PAD = PC_W - K_W;
    localparam NREGS = 32;

    // ----------------------------------------------------------------
    // State and instruction fields
    // ----------------------------------------------------------------
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [PC_W-1:0] pc_d;
    reg flush_d;
    reg [ADDR_W-1:0] mem_addr_d;
    reg [7:0] mem_wdata_d;
    reg mem_re_d;
    reg mem_we_d;
    reg [4:0] ld_dest_q;
    reg [4:0] ld_dest_d;
    reg byte_we;
    reg [4:0] byte_idx;
    reg [7:0] byte_data;
    reg word_we;
    reg [4:0] word_idx;
    reg [15:0] word_data;
    reg [4:0] ptr_base;
    reg ptr_legal;

    wire [3:0] op;
    wire [3:0] cond;
    wire [2:0] sel;
    wire [K_W-1:0] k;
    wire [4:0] rd;
    wire [4:0] rr;
    wire [1:0] ptr_sel;
    wire [1:0] mode;
    wire [5:0] q;
    wire [7:0] imm;
    wire [4:0] ptr_hi_idx;
    wire [4:0] word_hi_idx;
    wire [4:0] rr_lo_idx;
    wire [4:0] rr_hi_idx;
    wire [4:0] rd_lo_idx;
    wire [7:0] regs_w [0:NREGS-1];
    wire [15:0] ptr_value;
    wire [ADDR_W-1:0] access_addr;
    wire [15:0] ptr_next;
    wire ptr_write;
    wire mode_legal;
    wire use_disp;
    wire cond_taken;
    wire [PC_W-1:0] pc_plus_one;
    wire [PC_W-1:0] pc_target;
    wire accept;
    wire bus_reg_area;
    wire bus_reg_we;
    wire pc_busy;

    assign op = instr_word[`F_OP];
    assign cond = instr_word[`F_COND];
    assign sel = instr_word[`F_SEL];
    assign k = instr_word[`F_K];
    assign rd = instr_word[`F_RD];
    assign rr = instr_word[`F_RR];
    assign ptr_sel = instr_word[`F_PTR];
    assign mode = instr_word[`F_MODE];
    assign q = instr_word[`F_Q];
    assign imm = instr_word[`F_IMM];

    // Pairs are always even-aligned; the low index bit of a pair operand is ignored
    assign ptr_hi_idx = {ptr_base[4:1], 1'b1};
    assign word_hi_idx = {word_idx[4:1], 1'b1};
    assign rr_lo_idx = {rr[4:1], 1'b0};
    assign rr_hi_idx = {rr[4:1], 1'b1};
    assign rd_lo_idx = {rd[4:1], 1'b0};
    assign ptr_value = {regs_w[ptr_hi_idx], regs_w[ptr_base]};
    assign use_disp = (op == `OP_OFS_READ);

    // Offset k is signed; the extra one steps past the branch itself
    assign pc_plus_one = program_counter_q + `PC_STEP;
    assign pc_target = pc_plus_one + {{K_PAD{k[K_W-1]}}, k};

    // A new instruction is taken only between multi-cycle sequences
    assign instr_ready = (state_q == `ST_IDLE);
    assign accept = instr_ready & instr_valid;

    // ----------------------------------------------------------------
    // Helper units
    // ----------------------------------------------------------------
    branch_condition u_cond (
        .cond(cond),
        .sel(sel),
        .flags(status_flags_register_q),
        .taken(cond_taken)
    );

    pointer_address_unit #(
        .ADDR_W(ADDR_W),
        .Q_W(6)
    ) u_ptr (
        .ptr_value(ptr_value),
        .mode(mode),
        .q(q),
        .use_disp(use_disp),
        .access_addr(access_addr),
        .ptr_next(ptr_next),
        .ptr_write(ptr_write),
        .mode_legal(mode_legal)
    );

    // ----------------------------------------------------------------
    // Pointer pair selection
    // ----------------------------------------------------------------
    always @* begin
        ptr_base = `PTR_X_BASE;
        ptr_legal = 1'b1;
        case (ptr_sel)
            `PTR_X: begin
                ptr_base = `PTR_X_BASE;
                ptr_legal = ~use_disp;
            end
            `PTR_Y: ptr_base = `PTR_Y_BASE;
            `PTR_Z: ptr_base = `PTR_Z_BASE;
            default: ptr_legal = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always @* begin
        state_d = state_q;
        pc_d = program_counter_q;
        flush_d = 1'b0;
        mem_addr_d = mem_addr_q;
        mem_wdata_d = mem_wdata_q;
        mem_re_d = 1'b0;
        mem_we_d = 1'b0;
        ld_dest_d = ld_dest_q;
        byte_we = 1'b0;
        byte_idx = rd;
        byte_data = `REG_RESET;
        word_we = 1'b0;
        word_idx = ptr_base;
        word_data = ptr_next;
        case (state_q)
            `ST_IDLE: begin
                if (instr_valid) begin
                    pc_d = pc_plus_one;
                    case (op)
                        `OP_BRANCH: begin
                            if (cond_taken) begin
                                pc_d = pc_target;
                                state_d = `ST_FLUSH;
                                flush_d = 1'b1;
                            end
                        end
                        `OP_COPY: begin
                            byte_we = 1'b1;
                            byte_data = regs_w[rr];
                        end
                        `OP_PAIR_COPY: begin
                            word_we = 1'b1;
                            word_idx = rd_lo_idx;
                            word_data = {regs_w[rr_hi_idx], regs_w[rr_lo_idx]};
                        end
                        `OP_IMM: begin
                            byte_we = 1'b1;
                            byte_data = imm;
                        end
                        `OP_DIR_READ: begin
                            mem_addr_d = instr_addr;
                            mem_re_d = 1'b1;
                            ld_dest_d = rd;
                            state_d = `ST_MEM;
                        end
                        `OP_PTR_READ, `OP_OFS_READ: begin
                            if (ptr_legal && mode_legal) begin
                                mem_addr_d = access_addr;
                                mem_re_d = 1'b1;
                                ld_dest_d = rd;
                                word_we = ptr_write;
                                state_d = `ST_MEM;
                            end
                        end
                        `OP_PTR_WRITE: begin
                            if (ptr_legal && mode_legal) begin
                                mem_addr_d = access_addr;
                                mem_wdata_d = regs_w[rd];
                                mem_we_d = 1'b1;
                                word_we = ptr_write;
                                state_d = `ST_MEM;
                            end
                        end
                        default: pc_d = pc_plus_one;
                    endcase
                end
            end
            `ST_FLUSH: begin
                // Second cycle of a taken branch: the prefetched word is dropped
                state_d = `ST_IDLE;
            end
            `ST_MEM: begin
                state_d = `ST_IDLE;
                if (mem_re_q) begin
                    byte_we = 1'b1;
                    byte_idx = ld_dest_q;
                    byte_data = mem_rdata;
                end
            end
            default: state_d = `ST_IDLE;
        endcase
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    // Software may move the counter only while no instruction updates it
    assign pc_busy = accept | (state_q != `ST_IDLE);

    always @(posedge sys_clk) begin
        if (reset) begin
            state_q <= `ST_IDLE;
            program_counter_q <= `PC_RESET;
            flush_q <= 1'b0;
            mem_addr_q <= {ADDR_W{1'b0}};
            mem_wdata_q <= `REG_RESET;
            mem_re_q <= 1'b0;
            mem_we_q <= 1'b0;
            ld_dest_q <= 5'h00;
        end else if (ce) begin
            state_q <= state_d;
            flush_q <= flush_d;
            mem_addr_q <= mem_addr_d;
            mem_wdata_q <= mem_wdata_d;
            mem_re_q <= mem_re_d;
            mem_we_q <= mem_we_d;
            ld_dest_q <= ld_dest_d;
            if (pc_busy) begin
                program_counter_q <= pc_d;
            end else if (bus_we && bus_addr == `BUS_PC_LO) begin
                program_counter_q <= {program_counter_q[PC_W-1:8], bus_wdata};
            end else if (bus_we && bus_addr == `BUS_PC_HI) begin
                program_counter_q <= {bus_wdata[PC_W-9:0], program_counter_q[7:0]};
            end
        end
    end

    // ----------------------------------------------------------------
    // Status flags: none of these instructions alter them
    // ----------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (reset) begin
            status_flags_register_q <= `FLAGS_RESET;
        end else if (ce && bus_we && bus_addr == `BUS_FLAGS) begin
            status_flags_register_q <= bus_wdata;
        end
    end

    // ----------------------------------------------------------------
    // Working registers
    // ----------------------------------------------------------------
    assign bus_reg_area = ~bus_addr[`BUS_AREA_BIT];
    assign bus_reg_we = bus_we & bus_reg_area;

    genvar gi;
    generate
        for (gi = 0; gi < NREGS; gi = gi + 1) begin : g_reg
            localparam [4:0] IDX = gi;
            reg [7:0] entry_q;
            assign regs_w[gi] = entry_q;
            // Instruction writes win over a software write in the same cycle
            always @(posedge sys_clk) begin
                if (reset) begin
                    entry_q <= `REG_RESET;
                end else if (ce) begin
                    if (byte_we && byte_idx == IDX) begin
                        entry_q <= byte_data;
                    end else if (word_we && word_idx == IDX) begin
                        entry_q <= word_data[7:0];
                    end else if (word_we && word_hi_idx == IDX) begin
                        entry_q <= word_data[15:8];
                    end else if (bus_reg_we && bus_addr[4:0] == IDX) begin
                        entry_q <= bus_wdata;
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Software read port
    // ----------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (reset) begin
            bus_rdata_q <= `REG_RESET;
        end else if (ce) begin
            bus_rdata_q <= `REG_RESET;
            if (bus_re) begin
                if (bus_reg_area) begin
                    bus_rdata_q <= regs_w[bus_addr[4:0]];
                end else if (bus_addr == `BUS_FLAGS) begin
                    bus_rdata_q <= status_flags_register_q;
                end else if (bus_addr == `BUS_PC_LO) begin
                    bus_rdata_q <= program_counter_q[7:0];
                end else if (bus_addr == `BUS_PC_HI) begin
                    bus_rdata_q <= program_counter_q[PC_W-1:8];
                end
            end
        end
    end

endmodule // branch_and_load_store_exec

// ---- test/exec_checker_assertions.sv ----
// Port-level assertions for the branch and load/store execution unit
`timescale 1ns/1ps
module exec_checker #(
    parameter PC_W = 16,
    parameter ADDR_W = 16
) (
    input wire sys_clk, // Core clock
    input wire reset, // Synchronous reset
    input wire instr_valid, // Instruction offered
    input wire [23:0] instr_word, // Instruction word
    input wire [ADDR_W-1:0] instr_addr, // Direct address
    input wire instr_ready, // Unit idle
    input wire flush_q, // Fetched word dropped
    input wire [PC_W-1:0] program_counter_q, // Program counter
    input wire [7:0] status_flags_register_q, // Status flags
    input wire [ADDR_W-1:0] mem_addr_q, // Data-space address
    input wire mem_re_q, // Read strobe
    input wire mem_we_q, // Write strobe
    input wire bus_we // Software write strobe
);
reg [PC_W-1:0] inc_q;
reg [PC_W-1:0] tgt_q;
wire acc = instr_valid && instr_ready;
// Both candidate targets are kept so the branch check needs no $past of slices
always @(posedge sys_clk) begin
    inc_q <= program_counter_q + 1'b1;
    tgt_q <= program_counter_q + 1'b1 + {{(PC_W-7){instr_word[6]}}, instr_word[6:0]};
end
default clocking cb @(posedge sys_clk); endclocking
default disable iff (reset);
chk_pc_step: assert property (acc && instr_word[23:20] != 4'h1 |=> program_counter_q == inc_q)
    else $error("pc did not step by one");
chk_branch_target: assert property (acc && instr_word[23:20] == 4'h1 |=>
    program_counter_q == (flush_q ? tgt_q : inc_q)) else $error("branch target wrong");
chk_flush_pulse: assert property (flush_q |-> !instr_ready ##1 !flush_q && instr_ready)
    else $error("taken branch not two cycles");
chk_load_slot: assert property (mem_re_q |-> !instr_ready && !mem_we_q ##1 !mem_re_q && instr_ready)
    else $error("load not two cycles");
chk_store_slot: assert property (mem_we_q |-> !instr_ready ##1 !mem_we_q && instr_ready)
    else $error("store not two cycles");
chk_direct_addr: assert property (acc && instr_word[23:20] == 4'h8 |=>
    mem_re_q && mem_addr_q == $past(instr_addr)) else $error("direct read address wrong");
chk_flags_kept: assert property (acc && !bus_we |=> $stable(status_flags_register_q))
    else $error("instruction changed flags");
chk_copy_fast: assert property (acc && instr_word[23:20] inside {4'h2, 4'h3, 4'h4} |=>
    instr_ready && !mem_re_q && !mem_we_q && !flush_q) else $error("copy not one cycle");
endmodule // exec_checker
bind branch_and_load_store_exec exec_checker #(.PC_W(PC_W), .ADDR_W(ADDR_W)) i_chk (
    .sys_clk(sys_clk), .reset(reset), .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_addr(instr_addr), .instr_ready(instr_ready), .flush_q(flush_q),
    .program_counter_q(program_counter_q), .status_flags_register_q(status_flags_register_q),
    .mem_addr_q(mem_addr_q), .mem_re_q(mem_re_q), .mem_we_q(mem_we_q), .bus_we(bus_we));

// ---- test/data_space_model.sv ----
// Data-space memory answering the unit's read and write strobes
`timescale 1ns/1ps
module data_space_model (
    input wire sys_clk, // Core clock
    input wire [15:0] mem_addr_q, // Access address
    input wire [7:0] mem_wdata_q, // Write data
    input wire mem_re_q, // Read strobe
    input wire mem_we_q, // Write strobe
    output wire [7:0] mem_rdata // Read data
);
reg [7:0] m [0:255];
reg [7:0] idle_q = 8'h00;
integer i;
initial for (i = 0; i < 256; i = i + 1) m[i] = i[7:0] ^ 8'h5A;
// Outside a read strobe the line churns so stale data never looks valid
assign mem_rdata = mem_re_q ? m[mem_addr_q[7:0]] : idle_q;
always @(posedge sys_clk) begin
    idle_q <= ~idle_q + 8'h3B;
    if (mem_we_q) m[mem_addr_q[7:0]] <= mem_wdata_q;
end
endmodule // data_space_model

// ---- test/branch_and_load_store_exec_test.sv ----
// Self-checking bench for the branch and load/store execution unit
`timescale 1ns/1ps
module branch_and_load_store_exec_test;
reg sys_clk = 1'b0, reset = 1'b1, ce = 1'b1, instr_valid = 1'b0, bus_we = 1'b0, bus_re = 1'b0, t;
reg [23:0] instr_word = 24'h000000;
reg [15:0] instr_addr = 16'h0000, exp_pc = 16'h0000, ea;
reg [5:0] bus_addr = 6'h00;
reg [7:0] bus_wdata = 8'h00, base;
reg [6:0] k;
reg [2:0] s;
wire instr_ready, flush_q, mem_re_q, mem_we_q;
wire [15:0] program_counter_q, mem_addr_q;
wire [7:0] status_flags_register_q, mem_wdata_q, mem_rdata, bus_rdata_q;
integer bad_count = 0, num_checks = 0, cyc = 0, c, f, p, md, o;
branch_and_load_store_exec i_dut (.sys_clk(sys_clk), .reset(reset), .ce(ce), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_addr(instr_addr), .instr_ready(instr_ready), .flush_q(flush_q),
    .program_counter_q(program_counter_q), .status_flags_register_q(status_flags_register_q),
    .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q), .mem_re_q(mem_re_q), .mem_we_q(mem_we_q),
    .mem_rdata(mem_rdata), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_we(bus_we), .bus_re(bus_re),
    .bus_rdata_q(bus_rdata_q));
data_space_model i_mem (.sys_clk(sys_clk), .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q),
    .mem_re_q(mem_re_q), .mem_we_q(mem_we_q), .mem_rdata(mem_rdata));
initial forever #25 sys_clk = ~sys_clk;
always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
        bad_count = bad_count + 1;
        print_verdict;
    end
end
// ----------------------------------------------------------------
// Access tasks
// ----------------------------------------------------------------
task check(input [15:0] seen, input [15:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
endtask
task wr(input [5:0] a, input [7:0] d);
    bus_addr <= a;
    bus_wdata <= d;
    bus_we <= 1'b1;
    @(posedge sys_clk);
    bus_we <= 1'b0;
endtask
task rd(input [5:0] a, input [7:0] exp);
    bus_addr <= a;
    bus_re <= 1'b1;
    @(posedge sys_clk);
    bus_re <= 1'b0;
    @(posedge sys_clk);
    check(bus_rdata_q, exp);
endtask
// Counts cycles from acceptance until the unit is idle again
task issue(input [23:0] w, input [15:0] a, input [15:0] cy);
    integer n;
    instr_word <= w;
    instr_addr <= a;
    instr_valid <= 1'b1;
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    n = 1;
    @(posedge sys_clk);
    while (instr_ready !== 1'b1 && n < 8) begin
        n = n + 1;
        @(posedge sys_clk);
    end
    check(n[15:0], cy);
endtask
// Signed tests use N xor V, never the stored sign bit
function hold(input [3:0] cd, input [2:0] sl, input [7:0] fl);
    reg [7:0] v;
    begin
        v = {cd[0], fl[7], fl[5], ~(fl[2] ^ fl[3]), fl[2], fl[0], fl[1], fl[sl]};
        hold = v[cd[3:1]] ^ cd[0];
    end
endfunction
task print_verdict;
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
        $display("TEST PASSED");
    else
        $display("TEST FAILED");
    $finish;
endtask
// ----------------------------------------------------------------
// Tests
// ----------------------------------------------------------------
initial begin
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    rd(6'h20, 8'h00);
    rd(6'h21, 8'h00);
    wr(6'h30, 8'hFF);
    rd(6'h30, 8'h00);
    for (c = 0; c < 16; c = c + 1)
        for (f = 0; f < 4; f = f + 1) begin
            base = 32'hA60CFF00 >> (f * 8);
            s = c + f;
            k = f[0] ? 7'h40 : 7'h3F;
            t = hold(c[3:0], s, base);
            wr(6'h20, base);
            issue({4'h1, c[3:0], s, 6'h00, k}, 16'h0000, t ? 16'h0002 : 16'h0001);
            exp_pc = exp_pc + 16'h0001 + (t ? {{9{k[6]}}, k} : 16'h0000);
            check(program_counter_q, exp_pc);
        end
    wr(6'h06, 8'hC3);
    for (o = 5; o < 7; o = o + 1)
        for (p = 0; p < 3; p = p + 1)
            for (md = 0; md < 3; md = md + 1) begin
                base = 8'h40 + p * 16;
                ea = (md == 2) ? base - 1 : base;
                wr(6'h1A + p * 2, base);
                issue({o[3:0], 5'h07 - o[4:0] + 5'h05, p[1:0], md[1:0], 11'h000}, 16'h0000, 16'h0002);
                check(mem_addr_q, ea);
                if (o == 6)
                    check(mem_wdata_q, 8'hC3);
                else
                    rd(6'h07, ea[7:0] ^ 8'h5A);
                rd(6'h1A + p * 2, md == 0 ? base : md == 1 ? base + 1 : base - 1);
            end
    for (p = 1; p < 3; p = p + 1) begin
        wr(6'h1A + p * 2, 8'h80);
        issue({4'h7, 5'h06, p[1:0], 13'h003F}, 16'h0000, 16'h0002);
        check(mem_addr_q, 16'h00BF);
        rd(6'h06, 8'hBF ^ 8'h5A);
        rd(6'h1A + p * 2, 8'h80);
    end
    // Displacement through the first pair is refused and must leave the destination alone
    issue({4'h7, 5'h06, 2'h0, 13'h003F}, 16'h0000, 16'h0001);
    rd(6'h06, 8'hBF ^ 8'h5A);
    issue({4'h8, 5'h08, 15'h0000}, 16'h0077, 16'h0002);
    rd(6'h08, 8'h77 ^ 8'h5A);
    issue({4'h4, 5'h10, 7'h00, 8'hA7}, 16'h0000, 16'h0001);
    issue({4'h2, 5'h11, 5'h10, 10'h000}, 16'h0000, 16'h0001);
    issue({4'h4, 5'h10, 7'h00, 8'h3C}, 16'h0000, 16'h0001);
    issue({4'h3, 5'h12, 5'h10, 10'h000}, 16'h0000, 16'h0001);
    rd(6'h11, 8'hA7);
    rd(6'h12, 8'h3C);
    rd(6'h13, 8'hA7);
    wr(6'h21, 8'h34);
    rd(6'h21, 8'h34);
    wr(6'h22, 8'h12);
    rd(6'h22, 8'h12);
    check(program_counter_q, 16'h1234);
    // A write offered while the clock enable is low must not land
    ce <= 1'b0;
    wr(6'h10, 8'h55);
    ce <= 1'b1;
    rd(6'h10, 8'h3C);
    print_verdict;
end
endmodule // branch_and_load_store_exec_test
